// ### psl_pkg.sv
package psl_pkg;

   // Register bus shape
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;

   // Register offsets (byte addresses)
   localparam logic [15:0] OFS_ROOT_PORT_CONFIG = 16'h0224;
   localparam logic [15:0] OFS_GENERAL_CHIP_CONTROL = 16'h3410;
   localparam logic [15:0] OFS_BOOT_SWAP_CONTROL = 16'h3414;

   // Field positions
   localparam int BIT_PORT_CFG0 = 0;
   localparam int BIT_PORT_CFG1 = 1;
   localparam int BIT_BOOT_DEST = 3;
   localparam int BIT_NO_REBOOT = 5;
   localparam int BIT_TOP_SWAP = 0;
   localparam int BIT_SWAP_ADDR = 16;

   // Values after reset
   localparam logic RST_TOP_SWAP = 1'b0;
   localparam logic RST_NO_REBOOT = 1'b0;
   localparam logic RST_BOOT_DEST = 1'b0;
   localparam logic [1:0] RST_PORT_CFG = 2'h0;
   localparam logic RST_XOR_MODE = 1'b0;
   localparam logic RST_VRM25_STRAP = 1'b1;
   localparam logic RST_PG_PREV = 1'b0;
   localparam logic RST_RSM_PREV = 1'b0;

   // Pull-up release time on the 2.5 V regulator strap
   localparam int CLK_FREQ_KHZ = 100000;
   localparam int PULLUP_REL_MS = 100;
   localparam int PULLUP_REL_CYC = PULLUP_REL_MS * CLK_FREQ_KHZ;
   localparam int PULL_CNT_W = 24;

   // Boot firmware cycle carrier
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } psl_fw_cyc_type;

endpackage : psl_pkg

// ### psl_top.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module psl_top
   import psl_pkg::*;
#(
   parameter int PULLUP_CYC = PULLUP_REL_CYC
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic core_power_good,
   input wire logic resume_well_reset_n,
   input wire logic swap_strap_pin,
   input wire logic no_reboot_strap_pin,
   input wire logic resume_regulator_enable_pin,
   input wire logic boot_destination_pin,
   input wire logic audio_serial_out_strap,
   input wire logic audio_sync_strap,
   input wire logic test_entry_pin,
   input wire logic gpio25_in,
   output logic gpio25_out,
   output logic gpio25_oe_n,
   input wire logic wdt_reboot_req,
   output logic sys_reboot,
   input wire psl_fw_cyc_type fw_in,
   output psl_fw_cyc_type fw_out,
   output logic boot_to_lpc,
   output logic xor_chain_mode,
   output logic resume_reg_en,
   output logic vrm25_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata
);

   if (PULLUP_CYC < 1 || PULLUP_CYC > (2 ** PULL_CNT_W) - 1) begin : g_chk
      $error("PULLUP_CYC out of range");
   end

   logic pg_prev_r;
   logic rsm_prev_r;
   logic top_swap_r;
   logic top_swap_nxt;
   logic swap_locked_r;
   logic no_reboot_r;
   logic boot_dest_r;
   logic boot_dest_nxt;
   logic [1:0] port_cfg_r;
   logic [1:0] port_cfg_nxt;
   logic xor_mode_r;
   logic vrm25_strap_r;
   logic pull_on_r;
   logic [PULL_CNT_W-1:0] pull_cnt_r;
   logic [DATA_W-1:0] reg_rdata_nxt;
   psl_fw_cyc_type fw_out_r;

   // Edge detection on the sequencing inputs
   wire pg_rise = core_power_good & ~pg_prev_r;
   wire rsm_rise = resume_well_reset_n & ~rsm_prev_r;

   // Register decode
   wire sel_pcfg = (reg_addr == OFS_ROOT_PORT_CONFIG);
   wire sel_gcc = (reg_addr == OFS_GENERAL_CHIP_CONTROL);
   wire sel_bsc = (reg_addr == OFS_BOOT_SWAP_CONTROL);
   wire wr_gcc = reg_wr & sel_gcc;
   wire wr_bsc = reg_wr & sel_bsc;
   wire wdat_swap = reg_wdata[BIT_TOP_SWAP];
   wire wdat_dest = reg_wdata[BIT_BOOT_DEST];
   wire pull_done = (pull_cnt_r == PULL_CNT_W'(PULLUP_CYC - 1));

   always_ff @(posedge mclk) begin
      if (srst) begin
         pg_prev_r <= RST_PG_PREV;
         rsm_prev_r <= RST_RSM_PREV;
      end else begin
         pg_prev_r <= core_power_good;
         rsm_prev_r <= resume_well_reset_n;
      end
   end

   always_comb begin
      top_swap_nxt = top_swap_r;
      if (wr_bsc && (wdat_swap || !swap_locked_r)) begin
         top_swap_nxt = wdat_swap;
      end
      if (pg_rise) begin
         top_swap_nxt = ~swap_strap_pin;
      end
   end

   always_comb begin
      boot_dest_nxt = boot_dest_r;
      if (wr_gcc) begin
         boot_dest_nxt = wdat_dest;
      end
      if (pg_rise) begin
         boot_dest_nxt = boot_destination_pin;
      end
   end

   always_comb begin
      port_cfg_nxt = port_cfg_r;
      if (pg_rise) begin
         port_cfg_nxt[BIT_PORT_CFG0] = audio_sync_strap;
         if (test_entry_pin) begin
            port_cfg_nxt[BIT_PORT_CFG1] = audio_serial_out_strap;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         top_swap_r <= RST_TOP_SWAP;
         swap_locked_r <= RST_TOP_SWAP;
         boot_dest_r <= RST_BOOT_DEST;
         port_cfg_r <= RST_PORT_CFG;
      end else begin
         top_swap_r <= top_swap_nxt;
         boot_dest_r <= boot_dest_nxt;
         port_cfg_r <= port_cfg_nxt;
         if (pg_rise) begin
            swap_locked_r <= ~swap_strap_pin;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         no_reboot_r <= RST_NO_REBOOT;
         xor_mode_r <= RST_XOR_MODE;
      end else if (pg_rise) begin
         no_reboot_r <= no_reboot_strap_pin;
         xor_mode_r <= ~test_entry_pin;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         vrm25_strap_r <= RST_VRM25_STRAP;
      end else if (rsm_rise) begin
         vrm25_strap_r <= gpio25_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || !resume_well_reset_n) begin
         pull_on_r <= 1'b1;
         pull_cnt_r <= '0;
      end else if (pull_on_r) begin
         if (pull_done) begin
            pull_on_r <= 1'b0;
         end else begin
            pull_cnt_r <= pull_cnt_r + PULL_CNT_W'(1);
         end
      end
   end

   // Pull-up drives a constant high; enable is active low
   assign gpio25_out = 1'b1;
   assign gpio25_oe_n = ~pull_on_r;

   assign vrm25_en = ~vrm25_strap_r;
   assign resume_reg_en = resume_regulator_enable_pin;
   assign sys_reboot = wdt_reboot_req & ~no_reboot_r;

   assign boot_to_lpc = boot_dest_r;
   assign xor_chain_mode = xor_mode_r;

   always_ff @(posedge mclk) begin
      if (srst) begin
         fw_out_r <= '0;
      end else begin
         fw_out_r.valid <= fw_in.valid;
         fw_out_r.addr <= fw_in.addr;
         if (fw_in.valid && top_swap_r) begin
            fw_out_r.addr[BIT_SWAP_ADDR] <= ~fw_in.addr[BIT_SWAP_ADDR];
         end
      end
   end
   assign fw_out = fw_out_r;

   always_comb begin
      reg_rdata_nxt = '0;
      if (reg_rd) begin
         if (sel_pcfg) begin
            reg_rdata_nxt[1:0] = port_cfg_r;
         end
         if (sel_gcc) begin
            reg_rdata_nxt[BIT_NO_REBOOT] = no_reboot_r;
            reg_rdata_nxt[BIT_BOOT_DEST] = boot_dest_r;
         end
         if (sel_bsc) begin
            reg_rdata_nxt[BIT_TOP_SWAP] = top_swap_r;
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rdata_nxt;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   wire a16_in = fw_in.addr[BIT_SWAP_ADDR];
   wire a16_out = fw_out.addr[BIT_SWAP_ADDR];
   wire [DATA_W-1:0] rd_mon = reg_rdata;

   AST_A16_INVERT: assert property (
      fw_in.valid |=> a16_out == ($past(a16_in) ^ $past(top_swap_r)))
      else $error("A16 inversion wrong");

   AST_SWAP_CAPTURE: assert property (
      pg_rise |=> top_swap_r == !$past(swap_strap_pin))
      else $error("swap strap not captured");

   AST_SWAP_READ: assert property (
      reg_rd && sel_bsc |=> rd_mon[0] == $past(top_swap_r))
      else $error("swap readback wrong");

   AST_SWAP_NOCLEAR: assert property (
      swap_locked_r && top_swap_r && !pg_rise |=> top_swap_r)
      else $error("locked swap bit cleared");

   AST_NOREBOOT_LATCH: assert property (
      pg_rise ##1 !pg_rise [*3] |-> no_reboot_r == $past(no_reboot_strap_pin, 3))
      else $error("no-reboot not held");

   AST_NOREBOOT_BLOCK: assert property (
      no_reboot_r |-> !sys_reboot)
      else $error("reboot not suppressed");

   AST_NOREBOOT_READ: assert property (
      reg_rd && sel_gcc |=> rd_mon[5] == $past(no_reboot_r))
      else $error("no-reboot readback wrong");

   AST_VRM15_LEVEL: assert property (
      1'b1 |-> resume_reg_en == resume_regulator_enable_pin)
      else $error("resume regulator not following pin");

   AST_VRM25_CAPTURE: assert property (
      rsm_rise |=> vrm25_en == !$past(gpio25_in))
      else $error("2.5 V regulator strap wrong");

   AST_PULLUP_HELD: assert property (
      !resume_well_reset_n |=> !gpio25_oe_n && gpio25_out)
      else $error("pull-up missing in resume reset");

   AST_PULLUP_BOUND: assert property (
      pull_cnt_r <= PULL_CNT_W'(PULLUP_CYC - 1))
      else $error("pull-up held too long");

   AST_BOOT_DEST: assert property (
      pg_rise |=> boot_to_lpc == $past(boot_destination_pin))
      else $error("boot destination not captured");

   AST_BOOT_OVERRIDE: assert property (
      wr_gcc && !pg_rise |=> boot_to_lpc == $past(wdat_dest))
      else $error("boot destination override lost");

   AST_XOR_ENTRY: assert property (
      pg_rise && !test_entry_pin |=> xor_chain_mode)
      else $error("XOR-chain mode not entered");

   AST_PORT_CFG1: assert property (
      pg_rise |=> port_cfg_r[1] == ($past(test_entry_pin) ?
         $past(audio_serial_out_strap) : $past(port_cfg_r[1])))
      else $error("port config bit 1 wrong");

   AST_PORT_CFG0: assert property (
      pg_rise |=> port_cfg_r[0] == $past(audio_sync_strap))
      else $error("port config bit 0 wrong");

   AST_STRAP_HOLD: assert property (
      !pg_rise |=> $stable(port_cfg_r) && $stable(no_reboot_r))
      else $error("strap changed without edge");

   AST_FW_VALID: assert property (
      1'b1 |=> fw_out.valid == $past(fw_in.valid))
      else $error("firmware cycle valid not passed on");

   AST_SWAP_LOCKED_WR: assert property (
      wr_bsc && !wdat_swap && swap_locked_r && !pg_rise |=> $stable(top_swap_r))
      else $error("locked swap bit changed by clear");

   AST_SWAP_HOLD: assert property (
      !pg_rise && !wr_bsc |=> $stable(top_swap_r))
      else $error("swap bit changed without cause");

   AST_RDATA_IDLE: assert property (
      !reg_rd |=> rd_mon == '0)
      else $error("read data outside its cycle");

   AST_PULLUP_RELEASE: assert property (
      resume_well_reset_n && pull_done |=> gpio25_oe_n)
      else $error("pull-up not released");

   AST_VRM25_HOLD: assert property (
      !rsm_rise |=> $stable(vrm25_en))
      else $error("2.5 V regulator strap changed without edge");

   AST_XOR_HOLD: assert property (
      !pg_rise |=> $stable(xor_chain_mode))
      else $error("XOR-chain mode changed without edge");

endmodule : psl_top

`default_nettype wire

// ### psl_board.sv
`timescale 1ns/1ps
`default_nettype none
module psl_board (
   input wire logic mclk,
   input wire logic gpio25_out,
   input wire logic gpio25_oe_n,
   output logic core_power_good,
   output logic resume_well_reset_n,
   output logic [5:0] straps,
   output logic gpio25_in
);
   logic pd_r;
   logic last_r;
   // Board pull-down beats the weak pull-up; an open pin wanders
   assign gpio25_in = pd_r ? 1'b0 : (!gpio25_oe_n ? gpio25_out : ~last_r);
   always @(posedge mclk) begin
      last_r <= gpio25_in;
   end
   initial begin
      core_power_good = 1'b0;
      resume_well_reset_n = 1'b0;
      straps = 6'h29;
      pd_r = 1'b0;
      last_r = 1'b0;
   end
   // Order swap, no-reboot, dest, serial-out, sync, test pin
   task automatic power_cycle(input logic [5:0] s);
      @(posedge mclk);
      core_power_good <= 1'b0;
      // test pin low only for test
      straps <= s;
      repeat (2) @(posedge mclk);
      core_power_good <= 1'b1;
      @(posedge mclk);
      straps <= ~s;
   endtask : power_cycle
   task automatic resume_cycle(input logic pd);
      @(posedge mclk);
      resume_well_reset_n <= 1'b0;
      pd_r <= pd;
      repeat (3) @(posedge mclk);
      resume_well_reset_n <= 1'b1;
      @(posedge mclk);
   endtask : resume_cycle
endmodule : psl_board
`default_nettype wire

// ### psl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psl_top_tb;
   import psl_pkg::*;
   localparam logic [31:0] SWB = 32'h1 << BIT_TOP_SWAP;
   localparam logic [31:0] NRB = 32'h1 << BIT_NO_REBOOT;
   localparam logic [31:0] BDB = 32'h1 << BIT_BOOT_DEST;
   localparam logic [31:0] C0B = 32'h1 << BIT_PORT_CFG0;
   localparam logic [31:0] C1B = 32'h1 << BIT_PORT_CFG1;
   logic mclk, srst, wdt, rren, rd, wr, pg, rsm_n, g_in, g_out, g_oe_n;
   logic reboot, lpc, xm, rreg, v25;
   logic [5:0] st;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdat, rdat;
   psl_fw_cyc_type fin, fout;
   int miscompares, samples_checked;
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   psl_top #(.PULLUP_CYC(8)) i_psl_top (.mclk(mclk), .srst(srst),
      .core_power_good(pg), .resume_well_reset_n(rsm_n),
      .swap_strap_pin(st[5]), .no_reboot_strap_pin(st[4]),
      .resume_regulator_enable_pin(rren), .boot_destination_pin(st[3]),
      .audio_serial_out_strap(st[2]), .audio_sync_strap(st[1]),
      .test_entry_pin(st[0]), .gpio25_in(g_in), .gpio25_out(g_out),
      .gpio25_oe_n(g_oe_n), .wdt_reboot_req(wdt), .sys_reboot(reboot),
      .fw_in(fin), .fw_out(fout), .boot_to_lpc(lpc), .xor_chain_mode(xm),
      .resume_reg_en(rreg), .vrm25_en(v25), .reg_addr(addr),
      .reg_wdata(wdat), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
   psl_board i_psl_board (.mclk(mclk), .gpio25_out(g_out),
      .gpio25_oe_n(g_oe_n), .core_power_good(pg),
      .resume_well_reset_n(rsm_n), .straps(st), .gpio25_in(g_in));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdat, e);
   endtask : rd_reg
   task automatic fw_cyc(input logic [31:0] a, input logic [31:0] e);
      @(posedge mclk);
      fin <= '{1'b1, a};
      @(posedge mclk);
      fin <= '0;
      #1 chk(fout.addr, e);
      chk(fout.valid, 1);
   endtask : fw_cyc
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1;
      wdt = 1'b0;
      rren = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = '0;
      wdat = '0;
      fin = '0;
      miscompares = 0;
      samples_checked = 0;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      tick(2);
      chk(g_oe_n, 0);
      chk(v25, 0);
      wr_reg(16'h0100, 32'hFFFF_FFFF);
      rd_reg(16'h0100, 0);
      rd_reg(OFS_BOOT_SWAP_CONTROL, 0);
      rd_reg(OFS_GENERAL_CHIP_CONTROL, 0);
      rd_reg(OFS_ROOT_PORT_CONFIG, 0);
      i_psl_board.power_cycle(6'h1F);
      tick(3);
      rd_reg(OFS_BOOT_SWAP_CONTROL, SWB);
      rd_reg(OFS_GENERAL_CHIP_CONTROL, NRB | BDB);
      rd_reg(OFS_ROOT_PORT_CONFIG, C1B | C0B);
      chk(lpc, 1);
      chk(xm, 0);
      wr_reg(OFS_BOOT_SWAP_CONTROL, 0);
      rd_reg(OFS_BOOT_SWAP_CONTROL, SWB);
      fw_cyc(32'h000F_1234, 32'h000E_1234);
      @(posedge mclk);
      wdt <= 1'b1;
      #1 chk(reboot, 0);
      wr_reg(OFS_GENERAL_CHIP_CONTROL, 0);
      tick(0);
      chk(lpc, 0);
      rd_reg(OFS_GENERAL_CHIP_CONTROL, NRB);
      wr_reg(OFS_ROOT_PORT_CONFIG, 0);
      rd_reg(OFS_ROOT_PORT_CONFIG, C1B | C0B);
      i_psl_board.power_cycle(6'h20);
      tick(3);
      chk(xm, 1);
      chk(reboot, 1);
      chk(lpc, 0);
      rd_reg(OFS_BOOT_SWAP_CONTROL, 0);
      rd_reg(OFS_GENERAL_CHIP_CONTROL, 0);
      // Test pin low: bit 1 keeps its old value
      rd_reg(OFS_ROOT_PORT_CONFIG, C1B);
      wr_reg(OFS_BOOT_SWAP_CONTROL, SWB);
      rd_reg(OFS_BOOT_SWAP_CONTROL, SWB);
      wr_reg(OFS_BOOT_SWAP_CONTROL, 0);
      rd_reg(OFS_BOOT_SWAP_CONTROL, 0);
      fw_cyc(32'h000F_1234, 32'h000F_1234);
      i_psl_board.resume_cycle(1'b1);
      tick(2);
      chk(v25, 1);
      chk(g_oe_n, 0);
      chk(g_out, 1);
      for (int i = 0; i < 20 && g_oe_n !== 1'b1; i++) begin
         tick(1);
      end
      chk(g_oe_n, 1);
      if (g_oe_n !== 1'b1)
         report_and_stop();
      i_psl_board.resume_cycle(1'b0);
      tick(2);
      chk(v25, 0);
      for (int v = 1; v >= 0; v--) begin
         @(posedge mclk);
         rren <= v[0];
         #1 chk(rreg, v[0]);
      end
      report_and_stop();
   end
endmodule : psl_top_tb
`default_nettype wire
